// ===== bench/spi_host_model.sv
// Purpose: host master of the deploy and arming spi ports
// Assumes: spi clock period 160 ns, low and still outside frames
// Notes:   unselected data line shows the inverse of the driven one
`timescale 1ns/1ps
module spi_host_model (
    output logic sclk_dep,
    output logic cs_dep_n,
    output logic mosi_dep,
    output logic sclk_arm,
    output logic cs_arm_n,
    output logic mosi_arm,
    input wire logic miso_dep,
    input wire logic miso_arm
);
    logic sel = 1'b0;
    logic sclk = 1'b0;
    logic cs_n = 1'b1;
    logic mosi = 1'b0;
    logic [15:0] last_rx = 16'h0000;
    event done;
    // ==========================================================
    // port steering
    assign sclk_dep = !sel && sclk;
    assign sclk_arm = sel && sclk;
    assign cs_dep_n = sel || cs_n;
    assign cs_arm_n = !sel || cs_n;
    assign mosi_dep = sel ? ~mosi : mosi;
    assign mosi_arm = sel ? mosi : ~mosi;
    // ==========================================================
    // one frame of n clocks
    task automatic xfer(input logic arm, input int n, input logic [15:0] tx);
        logic [15:0] rx;
        rx = 16'h0000;
        sel = arm;
        #81.3;
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi = tx[i];
            #80;
            sclk = 1'b1;
            rx = {rx[14:0], arm ? miso_arm : miso_dep};
            #80;
            sclk = 1'b0;
        end
        #80;
        cs_n = 1'b1;
        mosi = ~mosi;
        last_rx = rx;
        -> done;
        #400;
    endtask : xfer
endmodule : spi_host_model

// ===== bench/squib_arm_sva.sv
// Purpose: port checks of the squib deploy and arming block
// Assumes: one clock domain clk_sys, async active-low rst_n
// Notes:   drivers lag the channel state by one clock
`timescale 1ns/1ps
module squib_arm_sva #(
    parameter int unsigned FIRE_CYC = 1,
    parameter int unsigned GLITCH_CYC = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cs_dep_n,
    input wire logic cs_arm_n,
    input wire logic miso_dep_oe,
    input wire logic miso_arm_oe,
    input wire logic deploy_permit_input,
    input wire logic [3:0] high_side_drive,
    input wire logic [3:0] low_side_drive,
    input wire logic [3:0] deploy_success,
    input wire logic [3:0] firing_active,
    input wire logic permit_filtered
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // helper counters
    logic in_q, in_d;
    int unsigned run_q, run_d, fire_q, fire_d;
    always_comb begin
        in_d = deploy_permit_input;
        run_d = (deploy_permit_input == in_q) ? run_q + 1 : 0;
        fire_d = firing_active[0] ? fire_q + 1 : 0;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            in_q <= 1'b0;
            run_q <= 0;
            fire_q <= 0;
        end else begin
            in_q <= in_d;
            run_q <= run_d;
            fire_q <= fire_d;
        end
    end
    // ==========================================================
    // assertions
    sequence fire_end_s;
        $fell(firing_active[0]);
    endsequence
    sequence fire_start_s;
        |(firing_active & ~$past(firing_active));
    endsequence
    AST_DEP_OE: assert property (miso_dep_oe == !cs_dep_n)
        else $error("deploy port output enable wrong");
    AST_ARM_OE: assert property (miso_arm_oe == !cs_arm_n)
        else $error("arming port output enable wrong");
    AST_FIRE_DRV: assert property ((high_side_drive & low_side_drive
        & $past(firing_active)) == $past(firing_active))
        else $error("firing channel drivers off");
    AST_FIRE_LEN: assert property (fire_end_s |-> fire_q == FIRE_CYC)
        else $error("firing length wrong");
    AST_SUCCESS: assert property (fire_end_s |-> ##[0:2] deploy_success[0])
        else $error("success flag not set");
    AST_FIRE_PERMIT: assert property (fire_start_s |-> $past(permit_filtered))
        else $error("firing started without permit");
    AST_DRV_PERMIT: assert property (|({high_side_drive, low_side_drive}
        & ~$past({high_side_drive, low_side_drive}))
        |-> $past(permit_filtered) || $past(permit_filtered, 2))
        else $error("driver turned on without permit");
    AST_GLITCH: assert property ($changed(permit_filtered)
        |-> run_q >= GLITCH_CYC)
        else $error("permit followed a short pulse");
endmodule : squib_arm_sva

// ===== bench/test_squib_deploy_arming_control.sv
// Purpose: self-checking bench of the squib deploy and arming block
// Assumes: host model drives both spi ports, bench drives the rest
// Notes:   deploy replies checked one frame late, drivers checked on rise
`timescale 1ns/1ps
module test_squib_deploy_arming_control;
    localparam int unsigned FIRE_CYC = 2000;
    localparam int unsigned GLITCH_CYC = 8;
    localparam int unsigned DIAG_CYC = 20;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic deploy_permit_input = 1'b1;
    logic [3:0] sb_cmp = 4'h0;
    logic [3:0] sg_cmp = 4'h0;
    logic sclk_dep, cs_dep_n, mosi_dep, miso_dep, miso_dep_oe;
    logic sclk_arm, cs_arm_n, mosi_arm, miso_arm, miso_arm_oe;
    logic [3:0] high_side_drive, low_side_drive, deploy_success;
    logic [3:0] firing_active;
    logic permit_filtered;
    logic [7:0] drv_prev = 8'h00;
    logic [7:0] rise, exp_d, r;
    logic [31:0] seed = 32'h00014f60;
    int num_errors = 0;
    int checks_done = 0;
    logic [15:0] exp_rep[$];
    logic [7:0] exp_drv[$];
    always #4 clk_sys = ~clk_sys;
    squib_deploy_arming_control #(.FIRE_CYC(FIRE_CYC),
        .GLITCH_CYC(GLITCH_CYC), .DIAG_CYC(DIAG_CYC)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .sclk_dep(sclk_dep),
        .cs_dep_n(cs_dep_n), .mosi_dep(mosi_dep), .miso_dep(miso_dep),
        .miso_dep_oe(miso_dep_oe), .sclk_arm(sclk_arm), .cs_arm_n(cs_arm_n),
        .mosi_arm(mosi_arm), .miso_arm(miso_arm), .miso_arm_oe(miso_arm_oe),
        .deploy_permit_input(deploy_permit_input), .sb_cmp(sb_cmp),
        .sg_cmp(sg_cmp), .high_side_drive(high_side_drive),
        .low_side_drive(low_side_drive), .deploy_success(deploy_success),
        .firing_active(firing_active), .permit_filtered(permit_filtered));
    spi_host_model host (.sclk_dep(sclk_dep), .cs_dep_n(cs_dep_n),
        .mosi_dep(mosi_dep), .sclk_arm(sclk_arm), .cs_arm_n(cs_arm_n),
        .mosi_arm(mosi_arm), .miso_dep(miso_dep), .miso_arm(miso_arm));
    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ ({32{s[31]}} & 32'h04c11db7);
    endfunction : lfsr
    task automatic check(input logic [15:0] seen, input logic [15:0] e);
        checks_done++;
        if (seen !== e) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, e);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    task automatic dep(input int n, input logic [15:0] tx, input logic [15:0] e);
        host.xfer(1'b0, n, tx);
        exp_rep.push_back(e);
    endtask : dep
    task automatic arm(input logic [7:0] b);
        host.xfer(1'b1, 8, {8'h00, b});
    endtask : arm
    task automatic permit_set(input logic v);
        @(negedge clk_sys);
        deploy_permit_input = v;
        repeat (GLITCH_CYC + 12) @(negedge clk_sys);
    endtask : permit_set
    task automatic wait_idle;
        repeat (2 * FIRE_CYC) begin
            @(negedge clk_sys);
            if (firing_active === 4'h0) break;
        end
        repeat (4) @(negedge clk_sys);
    endtask : wait_idle
    // ==========================================================
    // watchers
    always @(host.done) begin
        if (!host.sel && exp_rep.size() > 0)
            check(host.last_rx, exp_rep.pop_front());
    end
    always @(negedge clk_sys) begin
        rise = {high_side_drive, low_side_drive} & ~drv_prev;
        drv_prev = {high_side_drive, low_side_drive};
        if (rise != 8'h00) begin
            exp_d = 8'h00;
            if (exp_drv.size() > 0) exp_d = exp_drv.pop_front();
            check({8'h00, rise}, {8'h00, exp_d});
        end
    end
    initial begin
        #400000;
        num_errors++;
        give_verdict();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        seed = lfsr(seed);
        sb_cmp = seed[3:0];
        sg_cmp = seed[7:4];
        repeat (20) @(negedge clk_sys);
        dep(16, 16'h0000, 16'h0000);
        dep(15, 16'h0000, 16'he000);
        arm(8'h10);
        exp_drv.push_back(8'h11);
        dep(16, 16'h4010, 16'h4010);
        permit_set(1'b0);
        dep(16, 16'h0000, 16'he000);
        arm(8'h20);
        wait_idle();
        dep(16, 16'hc000, 16'hc100);
        dep(16, 16'h4040, 16'h4040);
        arm(8'h40);
        dep(16, 16'hc000, 16'hc104);
        arm(8'h04);
        dep(16, 16'h8011, {8'h80, sb_cmp, sg_cmp});
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            r = seed[7:0];
            dep(16, {8'h40, r}, {8'h40, r});
        end
        dep(16, 16'h0000, {8'h00, r});
        dep(16, 16'hc000, 16'hc100);
        @(negedge clk_sys);
        deploy_permit_input = 1'b1;
        repeat (3) @(negedge clk_sys);
        deploy_permit_input = 1'b0;
        permit_set(1'b1);
        dep(16, 16'h4020, 16'h4020);
        dep(16, 16'h4002, 16'h4002);
        arm(8'h20);
        dep(16, 16'hc000, 16'hd102);
        dep(16, 16'h4080, 16'h4080);
        arm(8'h08);
        exp_drv.push_back(8'h88);
        arm(8'h80);
        exp_drv.push_back(8'h22);
        dep(16, 16'h4020, 16'h4020);
        dep(16, 16'hc000, 16'hd1a0);
        wait_idle();
        exp_drv.push_back(8'h21);
        dep(16, 16'h8021, {8'h80, sb_cmp, sg_cmp});
        repeat (2 * DIAG_CYC) @(negedge clk_sys);
        arm(8'hf0);
        exp_drv.push_back(8'hff);
        dep(16, 16'h40f0, 16'h40f0);
        wait_idle();
        dep(16, 16'hc000, 16'hdf00);
        dep(16, 16'h0000, 16'h00f0);
        dep(16, 16'h0000, 16'h00f0);
        check(16'(exp_drv.size()), 16'h0000);
        give_verdict();
    end
endmodule : test_squib_deploy_arming_control

bind squib_deploy_arming_control squib_arm_sva #(.FIRE_CYC(FIRE_CYC),
    .GLITCH_CYC(GLITCH_CYC)) chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .cs_dep_n(cs_dep_n), .cs_arm_n(cs_arm_n), .miso_dep_oe(miso_dep_oe),
    .miso_arm_oe(miso_arm_oe), .deploy_permit_input(deploy_permit_input),
    .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
    .deploy_success(deploy_success), .firing_active(firing_active),
    .permit_filtered(permit_filtered));

// ===== shared/squib_cfg.svh
// Purpose: constants for the squib deploy and arming control block
// Assumes: system clock rate given in whole MHz
// Notes:   times are in microseconds, counts are derived from them
`ifndef SQUIB_CFG_SVH
`define SQUIB_CFG_SVH

// ==========================================================
// timing
`define SQB_SYS_MHZ 125
`define SQB_STRETCH_US 32000
`define SQB_FIRE_US 2000
`define SQB_GLITCH_US 10
`define SQB_DIAG_US 500
`define SQB_CYC(us) ((us) * `SQB_SYS_MHZ)

// ==========================================================
// frame lengths
`define SQB_DEP_BITS 8'h10
`define SQB_ARM_BITS 8'h08
`define SQB_DEP_MSB 4'hf
`define SQB_ARM_MSB 3'h7

// ==========================================================
// deployment frame fields
`define SQB_MODE_HI 15
`define SQB_MODE_LO 14
`define SQB_EN_HI 7
`define SQB_EN_LO 4
`define SQB_DIS_HI 3
`define SQB_DIS_LO 0

// ==========================================================
// reply tags in the top three bits
`define SQB_TAG_REG 3'h0
`define SQB_TAG_CMD 3'h2
`define SQB_TAG_DIAG 3'h4
`define SQB_TAG_MON 3'h6
`define SQB_TAG_FAULT 3'h7
`define SQB_FAULT_WORD 16'he000
`define SQB_PAD5 5'h00

`endif

// ===== shared/squib_pkg.sv
// Purpose: types shared by the squib deploy and arming control block
// Assumes: nothing
// Notes:   encodings written out
package squib_pkg;

    // ==========================================================
    // deployment frame modes
    typedef enum logic [1:0] {
        MODE_REG = 2'b00,
        MODE_CMD = 2'b01,
        MODE_DIAG = 2'b10,
        MODE_MON = 2'b11
    } mode_t;

    // ==========================================================
    // per-channel state
    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_ARM_RUN = 2'b01,
        CH_DEP_RUN = 2'b10,
        CH_FIRE = 2'b11
    } chan_st_t;

endpackage : squib_pkg

// ===== verilog/squib_deploy_arming_control.sv
// Purpose: four-channel squib deploy and arming control with two spi ports
// Assumes: spi clocks idle low outside frames, hosts keep chip selects apart
// Notes:   spi shift logic runs on the spi clocks, the rest on clk_sys
//
// Notes on behaviour
// - serial data outputs are released whenever their chip select is negated
// - outgoing words and bytes go most significant bit first
// - a completed firing sets a sticky success flag readable over spi
// - four channels, all able to fire together
// - drivers switch on only for firing or a switch diagnostic
// - each channel has its own stretch timer started by either command
// - arming byte is latched at arming select negation and starts timers
// - fire needs permit and a deploy/arm overlap inside the other's timer
// - firing runs its full fixed time, only reset ends it
// - deploy enable starts or restarts timer at deploy select negation
// - deploy disable stops only deploy-started runs
// - arm enable starts or restarts timer at arming select negation
// - arm disable stops only arm-started runs
// - while firing, register/diag frames faulted, commands skip firing ones
// - while firing, arming commands are ignored entirely
// - permit high allows drivers; dropping it never stops a firing
// - permit low keeps drivers off except for a running firing, diagnostics and spi keep working
// - permit low blocks deploy starts, deploy bits still echoed
// - arming starts timers whatever the permit level
// - a running timer ignores permit changes
// - permit level changes shorter than the deglitch time are ignored
// - deployment replies go out in the next frame
// - top two bits select mode, fault reply carries 111 on top
// - deploy frames not 16 clocks faulted, arming not multiple of 8 dropped
`timescale 1ns/1ps
`include "squib_cfg.svh"

module squib_deploy_arming_control #(
    parameter int unsigned STRETCH_CYC = `SQB_CYC(`SQB_STRETCH_US),
    parameter int unsigned FIRE_CYC = `SQB_CYC(`SQB_FIRE_US),
    parameter int unsigned GLITCH_CYC = `SQB_CYC(`SQB_GLITCH_US),
    parameter int unsigned DIAG_CYC = `SQB_CYC(`SQB_DIAG_US)
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclk_dep,
    input wire logic cs_dep_n,
    input wire logic mosi_dep,
    output logic miso_dep,
    output logic miso_dep_oe,
    input wire logic sclk_arm,
    input wire logic cs_arm_n,
    input wire logic mosi_arm,
    output logic miso_arm,
    output logic miso_arm_oe,
    input wire logic deploy_permit_input,
    input wire logic [3:0] sb_cmp,
    input wire logic [3:0] sg_cmp,
    output logic [3:0] high_side_drive,
    output logic [3:0] low_side_drive,
    output logic [3:0] deploy_success,
    output logic [3:0] firing_active,
    output logic permit_filtered
);

    // ==========================================================
    // helpers
    function automatic logic [7:0] frame_len(input logic [7:0] now,
                                             input logic [7:0] base);
        frame_len = now - base;
    endfunction : frame_len

    function automatic logic at_end(input logic [31:0] cnt,
                                    input int unsigned lim);
        at_end = (cnt == 32'(lim - 1));
    endfunction : at_end

    // ==========================================================
    // reset release
    logic rst_s1_q, rst_s2_q;
    logic rst_sync_n;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_sync_n = rst_s2_q;

    // ==========================================================
    // spi clock domains: shifting and bit counting
    logic [15:0] dep_rx_q, dep_rx_d;
    logic [7:0] dep_cnt_q, dep_cnt_d;
    logic [7:0] dep_tx_q, dep_tx_d;
    logic [7:0] arm_rx_q, arm_rx_d;
    logic [7:0] arm_cnt_q, arm_cnt_d;
    logic [7:0] arm_tx_q, arm_tx_d;

    always_comb begin
        dep_rx_d = {dep_rx_q[14:0], mosi_dep};
        dep_cnt_d = dep_cnt_q + 8'h01;
        dep_tx_d = dep_tx_q + 8'h01;
        arm_rx_d = {arm_rx_q[6:0], mosi_arm};
        arm_cnt_d = arm_cnt_q + 8'h01;
        arm_tx_d = arm_tx_q + 8'h01;
    end

    always_ff @(posedge sclk_dep or negedge rst_n) begin
        if (!rst_n) begin
            dep_rx_q <= 16'h0000;
            dep_cnt_q <= 8'h00;
        end else begin
            dep_rx_q <= dep_rx_d;
            dep_cnt_q <= dep_cnt_d;
        end
    end

    always_ff @(negedge sclk_dep or negedge rst_n) begin
        if (!rst_n) begin
            dep_tx_q <= 8'h00;
        end else begin
            dep_tx_q <= dep_tx_d;
        end
    end

    always_ff @(posedge sclk_arm or negedge rst_n) begin
        if (!rst_n) begin
            arm_rx_q <= 8'h00;
            arm_cnt_q <= 8'h00;
        end else begin
            arm_rx_q <= arm_rx_d;
            arm_cnt_q <= arm_cnt_d;
        end
    end

    always_ff @(negedge sclk_arm or negedge rst_n) begin
        if (!rst_n) begin
            arm_tx_q <= 8'h00;
        end else begin
            arm_tx_q <= arm_tx_d;
        end
    end

    // ==========================================================
    // input synchronisers and permit deglitch
    logic [2:0] csd_q, csd_d, csa_q, csa_d;
    logic [1:0] perm_q, perm_d;
    logic [3:0] sb_s1_q, sb_q, sg_s1_q, sg_q;
    logic [31:0] glitch_q, glitch_d;
    logic permit_q, permit_d;
    logic dep_end, arm_end;

    always_comb begin
        csd_d = {csd_q[1:0], cs_dep_n};
        csa_d = {csa_q[1:0], cs_arm_n};
        perm_d = {perm_q[0], deploy_permit_input};
        glitch_d = 32'h0000_0000;
        permit_d = permit_q;
        if (perm_q[1] != permit_q) begin
            if (at_end(glitch_q, GLITCH_CYC)) begin
                permit_d = perm_q[1];
            end else begin
                glitch_d = glitch_q + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            csd_q <= 3'h7;
            csa_q <= 3'h7;
            perm_q <= 2'h0;
            sb_s1_q <= 4'h0;
            sb_q <= 4'h0;
            sg_s1_q <= 4'h0;
            sg_q <= 4'h0;
            glitch_q <= 32'h0000_0000;
            permit_q <= 1'b0;
        end else begin
            csd_q <= csd_d;
            csa_q <= csa_d;
            perm_q <= perm_d;
            sb_s1_q <= sb_cmp;
            sb_q <= sb_s1_q;
            sg_s1_q <= sg_cmp;
            sg_q <= sg_s1_q;
            glitch_q <= glitch_d;
            permit_q <= permit_d;
        end
    end

    // rising chip select, seen after the spi clock has stopped
    assign dep_end = csd_q[1] && !csd_q[2];
    assign arm_end = csa_q[1] && !csa_q[2];

    // ==========================================================
    // frame decode
    logic [7:0] dep_base_q, dep_base_d, dep_txb_q, dep_txb_d;
    logic [7:0] arm_base_q, arm_base_d, arm_txb_q, arm_txb_d;
    logic [7:0] dep_len, arm_len;
    logic dep_ok, arm_ok, any_fire;
    squib_pkg::mode_t dep_mode;
    logic dep_cmd_evt, arm_evt, diag_evt;
    logic [3:0] den, ddis, aen, adis;

    assign dep_len = frame_len(dep_cnt_q, dep_base_q);
    assign arm_len = frame_len(arm_cnt_q, arm_base_q);
    assign dep_ok = (dep_len == `SQB_DEP_BITS);
    assign arm_ok = (arm_len != 8'h00) &&
                    (arm_len[2:0] == 3'h0);
    assign dep_mode = squib_pkg::mode_t'(dep_rx_q[`SQB_MODE_HI:`SQB_MODE_LO]);
    assign dep_cmd_evt = dep_end && dep_ok &&
                         (dep_mode == squib_pkg::MODE_CMD);
    assign diag_evt = dep_end && dep_ok && !any_fire &&
                      (dep_mode == squib_pkg::MODE_DIAG);
    assign arm_evt = arm_end && arm_ok && !any_fire;
    assign den = dep_rx_q[`SQB_EN_HI:`SQB_EN_LO];
    assign ddis = dep_rx_q[`SQB_DIS_HI:`SQB_DIS_LO];
    assign aen = arm_rx_q[`SQB_EN_HI:`SQB_EN_LO];
    assign adis = arm_rx_q[`SQB_DIS_HI:`SQB_DIS_LO];

    always_comb begin
        dep_base_d = dep_end ? dep_cnt_q : dep_base_q;
        dep_txb_d = dep_end ? dep_tx_q : dep_txb_q;
        arm_base_d = arm_end ? arm_cnt_q : arm_base_q;
        arm_txb_d = arm_end ? arm_tx_q : arm_txb_q;
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dep_base_q <= 8'h00;
            dep_txb_q <= 8'h00;
            arm_base_q <= 8'h00;
            arm_txb_q <= 8'h00;
        end else begin
            dep_base_q <= dep_base_d;
            dep_txb_q <= dep_txb_d;
            arm_base_q <= arm_base_d;
            arm_txb_q <= arm_txb_d;
        end
    end

    // ==========================================================
    // channels: stretch timers and firing
    squib_pkg::chan_st_t st_q [4];
    squib_pkg::chan_st_t st_d [4];
    logic [31:0] cnt_q [4];
    logic [31:0] cnt_d [4];
    logic [3:0] succ_q, succ_d, fire_v, arm_run;

    always_comb begin
        succ_d = succ_q;
        for (int i = 0; i < 4; i++) begin
            st_d[i] = st_q[i];
            cnt_d[i] = cnt_q[i] + 32'h0000_0001;
            unique case (st_q[i])
                squib_pkg::CH_IDLE: begin
                    cnt_d[i] = 32'h0000_0000;
                    if (arm_evt && aen[i]) begin
                        st_d[i] = squib_pkg::CH_ARM_RUN;
                    end else if (dep_cmd_evt && den[i] && permit_q) begin
                        st_d[i] = squib_pkg::CH_DEP_RUN;
                    end
                end
                squib_pkg::CH_ARM_RUN: begin
                    if (dep_cmd_evt && den[i] && permit_q) begin
                        st_d[i] = squib_pkg::CH_FIRE;
                        cnt_d[i] = 32'h0000_0000;
                    end else if (arm_evt && aen[i]) begin
                        cnt_d[i] = 32'h0000_0000;
                    end else if (arm_evt && adis[i]) begin
                        st_d[i] = squib_pkg::CH_IDLE;
                    end else if (at_end(cnt_q[i], STRETCH_CYC)) begin
                        st_d[i] = squib_pkg::CH_IDLE;
                    end
                end
                squib_pkg::CH_DEP_RUN: begin
                    if (arm_evt && aen[i] && permit_q) begin
                        st_d[i] = squib_pkg::CH_FIRE;
                        cnt_d[i] = 32'h0000_0000;
                    end else if (dep_cmd_evt && den[i] && permit_q) begin
                        cnt_d[i] = 32'h0000_0000;
                    end else if (dep_cmd_evt && ddis[i]) begin
                        st_d[i] = squib_pkg::CH_IDLE;
                    end else if (at_end(cnt_q[i], STRETCH_CYC)) begin
                        st_d[i] = squib_pkg::CH_IDLE;
                    end
                end
                squib_pkg::CH_FIRE: begin
                    if (at_end(cnt_q[i], FIRE_CYC)) begin
                        st_d[i] = squib_pkg::CH_IDLE;
                        succ_d[i] = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < 4; i++) begin
                st_q[i] <= squib_pkg::CH_IDLE;
                cnt_q[i] <= 32'h0000_0000;
            end
            succ_q <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                st_q[i] <= st_d[i];
                cnt_q[i] <= cnt_d[i];
            end
            succ_q <= succ_d;
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            fire_v[i] = (st_q[i] == squib_pkg::CH_FIRE);
            arm_run[i] = (st_q[i] == squib_pkg::CH_ARM_RUN);
        end
    end
    assign any_fire = |fire_v;

    // ==========================================================
    // switch diagnostic and drivers
    logic [3:0] dhs_q, dhs_d, dls_q, dls_d;
    logic [31:0] dcnt_q, dcnt_d;
    logic [3:0] hs_q, hs_d, ls_q, ls_d;

    always_comb begin
        dhs_d = dhs_q;
        dls_d = dls_q;
        dcnt_d = dcnt_q + 32'h0000_0001;
        if (diag_evt) begin
            dhs_d = den;
            dls_d = ddis;
            dcnt_d = 32'h0000_0000;
        end else if ((dhs_q | dls_q) == 4'h0) begin
            dcnt_d = 32'h0000_0000;
        end else if (at_end(dcnt_q, DIAG_CYC)) begin
            dhs_d = 4'h0;
            dls_d = 4'h0;
        end
        hs_d = fire_v | (dhs_q & {4{permit_q}});
        ls_d = fire_v | (dls_q & {4{permit_q}});
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dhs_q <= 4'h0;
            dls_q <= 4'h0;
            dcnt_q <= 32'h0000_0000;
            hs_q <= 4'h0;
            ls_q <= 4'h0;
        end else begin
            dhs_q <= dhs_d;
            dls_q <= dls_d;
            dcnt_q <= dcnt_d;
            hs_q <= hs_d;
            ls_q <= ls_d;
        end
    end

    // ==========================================================
    // replies
    logic [15:0] dep_rep_q, dep_rep_d;
    logic [7:0] echo_q, echo_d;
    logic [7:0] arm_rep_q, arm_rep_d;

    always_comb begin
        dep_rep_d = dep_rep_q;
        echo_d = dep_cmd_evt ? dep_rx_q[7:0] : echo_q;
        arm_rep_d = csa_q[2] ? {arm_run, fire_v} : arm_rep_q;
        if (dep_end) begin
            if (!dep_ok) begin
                dep_rep_d = `SQB_FAULT_WORD;
            end else begin
                unique case (dep_mode)
                    squib_pkg::MODE_REG: begin
                        dep_rep_d = any_fire ? `SQB_FAULT_WORD :
                            {`SQB_TAG_REG, `SQB_PAD5, echo_q};
                    end
                    squib_pkg::MODE_CMD: begin
                        dep_rep_d = {`SQB_TAG_CMD, `SQB_PAD5,
                                     dep_rx_q[7:0]};
                    end
                    squib_pkg::MODE_DIAG: begin
                        dep_rep_d = any_fire ? `SQB_FAULT_WORD :
                            {`SQB_TAG_DIAG, `SQB_PAD5, sb_q, sg_q};
                    end
                    squib_pkg::MODE_MON: begin
                        dep_rep_d = {`SQB_TAG_MON, permit_q, succ_q,
                                     fire_v, arm_run};
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dep_rep_q <= 16'h0000;
            echo_q <= 8'h00;
            arm_rep_q <= 8'h00;
        end else begin
            dep_rep_q <= dep_rep_d;
            echo_q <= echo_d;
            arm_rep_q <= arm_rep_d;
        end
    end

    // ==========================================================
    // serial outputs, bit index counted by falling spi edges
    logic [7:0] dep_idx, arm_idx;
    assign dep_idx = frame_len(dep_tx_q, dep_txb_q);
    assign arm_idx = frame_len(arm_tx_q, arm_txb_q);

    always_comb begin
        miso_dep_oe = !cs_dep_n;
        miso_arm_oe = !cs_arm_n;
        miso_dep = 1'b0;
        miso_arm = 1'b0;
        if (!cs_dep_n) begin
            miso_dep = dep_rep_q[`SQB_DEP_MSB - dep_idx[3:0]];
        end
        if (!cs_arm_n) begin
            if (arm_idx < `SQB_ARM_BITS) begin
                miso_arm = arm_rep_q[`SQB_ARM_MSB - arm_idx[2:0]];
            end else begin
                miso_arm = arm_rx_q[7];
            end
        end
    end

    assign high_side_drive = hs_q;
    assign low_side_drive = ls_q;
    assign deploy_success = succ_q;
    assign firing_active = fire_v;
    assign permit_filtered = permit_q;

endmodule : squib_deploy_arming_control
